// >>> hdl/atc_consts.svh
`ifndef ATC_CONSTS_SVH
`define ATC_CONSTS_SVH

// register byte offsets
`define ATC_OFF_COUNT 8'h00
`define ATC_OFF_COMPARE 8'h04
`define ATC_OFF_CONTROL 8'h08
`define ATC_OFF_STATUS 8'h0C
`define ATC_OFF_SFR 8'h10
`define ATC_OFF_FLAGS 8'h14

// async_status_reg bits
`define ATC_BIT_ASEL 3
`define ATC_BIT_CNT_UB 2
`define ATC_BIT_CMP_UB 1
`define ATC_BIT_CTL_UB 0
// special_function_reg bit
`define ATC_BIT_PSR 0
// flag register bits
`define ATC_BIT_OVF 0
`define ATC_BIT_CMPF 1

// timer_control fields
`define ATC_CS_MSB 2
`define ATC_CS_LSB 0
`define ATC_COM_MSB 5
`define ATC_COM_LSB 4

// clock_source_select codes
`define ATC_CS_STOP 3'h0
`define ATC_CS_DIRECT 3'h1
`define ATC_CS_DIV8 3'h2
`define ATC_CS_DIV32 3'h3
`define ATC_CS_DIV64 3'h4
`define ATC_CS_DIV128 3'h5
`define ATC_CS_DIV256 3'h6
`define ATC_CS_DIV1024 3'h7

// prescaler width and terminal masks
`define ATC_PSC_W 10
`define ATC_MASK_DIV8 10'h007
`define ATC_MASK_DIV32 10'h01F
`define ATC_MASK_DIV64 10'h03F
`define ATC_MASK_DIV128 10'h07F
`define ATC_MASK_DIV256 10'h0FF
`define ATC_MASK_DIV1024 10'h3FF

// compare output actions
`define ATC_COM_TOGGLE 2'h1
`define ATC_COM_CLEAR 2'h2
`define ATC_COM_SET 2'h3

// timing counts
`define ATC_XFER_EDGES 2'h2
`define ATC_HOLD_LAST 3'h3
`define ATC_COUNT_MAX 8'hFF

// sleep mode codes from the core
`define ATC_SLEEP_PDOWN 3'h2
`define ATC_SLEEP_STANDBY 3'h6

// axi responses and resets
`define ATC_RESP_OKAY 2'h0
`define ATC_RESP_SLVERR 2'h2
`define ATC_REG_RESET 8'h00

`endif

// >>> hdl/atc_pkg.sv
`include "atc_consts.svh"

package atc_pkg;

	typedef enum logic [1:0] {
		atc_w_idle = 2'b00,
		atc_w_pend = 2'b01,
		atc_w_hold = 2'b11,
		atc_w_rearm = 2'b10
	} atc_wake_t;

	typedef struct packed {
		logic [7:0] value;
		logic busy;
		logic [1:0] edges;
	} atc_hold_t;

	typedef struct packed {
		logic [`ATC_PSC_W-1:0] cnt;
	} atc_psc_state_t;

	typedef struct packed {
		logic xs1;
		logic xs2;
		logic xs3;
		logic asel;
		logic [7:0] count;
		logic [7:0] compare;
		logic [7:0] control;
		logic [7:0] count_copy;
		atc_hold_t h_cnt;
		atc_hold_t h_cmp;
		atc_hold_t h_ctl;
		logic [2:0] busy_s1;
		logic [2:0] busy_s2;
		logic [2:0] ovf_pipe;
		logic [2:0] cmp_pipe;
		logic flag_ovf;
		logic flag_cmp;
		logic cmp_block;
		logic oc_out;
		logic xout;
		logic psr;
		atc_wake_t wake;
		logic [2:0] hold_cnt;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} atc_state_t;

endpackage

// >>> hdl/atc_psc_if.sv
`timescale 1ns/1ps

interface atc_psc_if;
	logic src_en;
	logic clr;
	logic [2:0] sel;
	logic tick;

	modport ctrl (output src_en, output clr, output sel, input tick);
	modport psc (input src_en, input clr, input sel, output tick);
endinterface

// >>> hdl/atc_prescaler.sv
`timescale 1ns/1ps
`include "atc_consts.svh"

module atc_prescaler (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// control from the timer
	atc_psc_if.psc p
);
	atc_pkg::atc_psc_state_t st;
	atc_pkg::atc_psc_state_t nx;
	logic [`ATC_PSC_W-1:0] mask;
	logic tick_c;

	always_comb begin
		nx = st;
		mask = `ATC_MASK_DIV8;
		tick_c = 1'b0;
		// clear beats count so the next tick lands a full period later
		if (p.clr) begin
			nx.cnt = '0; // [R21]
		end else if (p.src_en) begin
			nx.cnt = st.cnt + 1'b1;
		end
		unique case (p.sel) // [R20] [R27]
			`ATC_CS_STOP: tick_c = 1'b0;
			`ATC_CS_DIRECT: tick_c = p.src_en;
			`ATC_CS_DIV8: mask = `ATC_MASK_DIV8;
			`ATC_CS_DIV32: mask = `ATC_MASK_DIV32;
			`ATC_CS_DIV64: mask = `ATC_MASK_DIV64;
			`ATC_CS_DIV128: mask = `ATC_MASK_DIV128;
			`ATC_CS_DIV256: mask = `ATC_MASK_DIV256;
			`ATC_CS_DIV1024: mask = `ATC_MASK_DIV1024;
		endcase
		if (p.sel != `ATC_CS_STOP && p.sel != `ATC_CS_DIRECT) begin
			tick_c = p.src_en && !p.clr && ((st.cnt & mask) == mask); // [R20]
		end
	end

	assign p.tick = tick_c;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= nx;
		end
	end
endmodule

// >>> hdl/atc_timer_front.sv
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`include "atc_consts.svh"

// Overview of operation
// R01: counter is aclk logic; prescaled tick is only a count enable.
// R02: crystal selected means counter advances on crystal edges, not aclk.
// R03: crystal-mode writes go to holding register, land after two crystal edges.
// R04: software waits for busy clear before rewriting a crystal-mode register.
// R05: count, compare and control each own a separate holding register.
// R06: status register shows busy for each pending holding transfer.
// R07: compare match suppressed while count or compare write is pending.
// R08: system runs aclk above four times the crystal frequency.
// R09: crystal is 32.768 kHz; no external clock into crystal input.
// R10: wake logic needs one crystal cycle to rearm after a wake-up.
// R11: oscillator runs in all sleep modes except power-down and standby.
// R12: software treats timer registers as lost after power-down or standby.
// R13: wake-up begins on the timer tick after the interrupt condition.
// R14: after wake, core held four cycles, then handler starts.
// R15: count read through copy refreshed on every crystal rising edge.
// R16: flags reach the core three cycles plus one timer cycle late.
// R17: compare output pin changes straight from timer logic.
// R18: main clock is default source; select bit moves source to crystal.
// R19: select bit set disconnects both crystal pins from port use.
// R20: prescaler offers /8,/32,/64,/128,/256,/1024, undivided and stop.
// R21: prescaler reset bit clears the prescaler for a predictable tick.
// R22: software follows the documented clock-switch sequence.
// R23: software waits for update before power-save with timer wake.
// R24: software writes and waits on busy before reading count after wake.
// R25: count busy set on crystal-mode write, cleared once count loaded.
// R26: select bit zero picks aclk, one picks the crystal.
// R27: select code 0 stops, 1 undivided, 2..7 ascending divides.
// R28: busy flags and crystal events cross through two flip-flops.
module atc_timer_front #(
	parameter int ADDR_W = 8
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// crystal pins
	input wire logic crystal_in_pin,
	output logic crystal_out_pin,
	output logic crystal_pins_claimed,
	output logic osc_enable,
	// compare output pin
	output logic compare_out,
	// sleep and wake with the core
	input wire logic sleep_active,
	input wire logic [2:0] sleep_mode,
	output logic wake_req,
	output logic cpu_hold,
	output logic handler_start
);
	atc_pkg::atc_state_t st;
	atc_pkg::atc_state_t nx;
	atc_psc_if psc_bus();

	logic xtal_edge;
	logic tick;
	logic wr_go;
	logic rd_go;
	logic [7:0] wbyte;
	logic ovf_evt;
	logic cmp_evt;
	logic [2:0] busy_raw;

	logic deep_sleep;
	logic wake_evt;
	logic [2:0] busy_seen;
	logic match_raw;
	logic xfer_pending;
	logic land_cnt;
	logic land_cmp;
	logic land_ctl;

	atc_prescaler u_psc (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.p(psc_bus.psc)
	);

	// edge taken from second and third stage only
	assign xtal_edge = st.xs2 && !st.xs3; // [R28]
	assign psc_bus.src_en = st.asel ? xtal_edge : 1'b1; // [R02] [R18] [R26]
	assign psc_bus.clr = st.psr; // [R21]
	assign psc_bus.sel = st.control[`ATC_CS_MSB:`ATC_CS_LSB]; // [R27]
	assign tick = psc_bus.tick; // [R01]

	assign wr_go = ce && s_axi_awvalid && s_axi_wvalid && !st.bvalid;
	assign rd_go = ce && s_axi_arvalid && !st.rvalid;
	assign wbyte = s_axi_wdata[7:0];
	assign busy_raw = {st.h_cnt.busy, st.h_cmp.busy, st.h_ctl.busy};
	// status ors in the raw flag so a read right after the write sees busy
	assign busy_seen = busy_raw | st.busy_s2; // [R06]
	assign deep_sleep = sleep_active && (sleep_mode == `ATC_SLEEP_PDOWN
		|| sleep_mode == `ATC_SLEEP_STANDBY);

	// compare match held off while a count or compare transfer is in flight
	assign match_raw = st.count == st.compare;
	assign xfer_pending = st.h_cnt.busy || st.h_cmp.busy;
	assign cmp_evt = tick && match_raw && !st.cmp_block && !xfer_pending; // [R07]
	assign ovf_evt = tick && st.count == `ATC_COUNT_MAX;
	assign wake_evt = sleep_active && (ovf_evt || cmp_evt);

	// a holding register lands on the crystal edge that completes its count
	assign land_cnt = st.h_cnt.busy && xtal_edge
		&& (st.h_cnt.edges == `ATC_XFER_EDGES - 2'h1); // [R03]
	assign land_cmp = st.h_cmp.busy && xtal_edge
		&& (st.h_cmp.edges == `ATC_XFER_EDGES - 2'h1); // [R03]
	assign land_ctl = st.h_ctl.busy && xtal_edge
		&& (st.h_ctl.edges == `ATC_XFER_EDGES - 2'h1); // [R03]

	always_comb begin
		logic cnt_load;
		logic [7:0] cnt_val;
		logic wr_ok;
		cnt_load = 1'b0;
		cnt_val = st.count;
		wr_ok = 1'b0;
		nx = st;

		// crystal input synchroniser
		nx.xs1 = crystal_in_pin; // [R28]
		nx.xs2 = st.xs1;
		nx.xs3 = st.xs2;
		nx.xout = osc_enable && !st.xs2;
		nx.psr = 1'b0;

		// holding register transfers on crystal edges
		if (st.h_cnt.busy && xtal_edge) begin
			nx.h_cnt.edges = st.h_cnt.edges + 1'b1;
			if (land_cnt) begin
				cnt_load = 1'b1; // [R03]
				cnt_val = st.h_cnt.value;
				nx.h_cnt.busy = 1'b0; // [R25]
			end
		end
		if (st.h_cmp.busy && xtal_edge) begin
			nx.h_cmp.edges = st.h_cmp.edges + 1'b1;
			if (land_cmp) begin
				nx.compare = st.h_cmp.value; // [R03]
				nx.h_cmp.busy = 1'b0;
			end
		end
		if (st.h_ctl.busy && xtal_edge) begin
			nx.h_ctl.edges = st.h_ctl.edges + 1'b1;
			if (land_ctl) begin
				nx.control = st.h_ctl.value; // [R03]
				nx.h_ctl.busy = 1'b0;
			end
		end

		// counter and compare output
		if (tick) begin
			nx.count = st.count + 1'b1; // [R01]
			nx.cmp_block = 1'b0;
		end
		if (cmp_evt) begin
			unique case (st.control[`ATC_COM_MSB:`ATC_COM_LSB]) // [R17]
				`ATC_COM_TOGGLE: nx.oc_out = !st.oc_out;
				`ATC_COM_CLEAR: nx.oc_out = 1'b0;
				`ATC_COM_SET: nx.oc_out = 1'b1;
				default: nx.oc_out = st.oc_out;
			endcase
		end

		// flag crossing: tick event, then three aclk stages
		nx.ovf_pipe = {st.ovf_pipe[1:0], ovf_evt}; // [R16]
		nx.cmp_pipe = {st.cmp_pipe[1:0], cmp_evt}; // [R16]
		nx.busy_s1 = busy_raw; // [R28]
		nx.busy_s2 = st.busy_s1;

		// copy seen by software; stale after wake until a crystal edge
		if (!st.asel || xtal_edge) begin
			nx.count_copy = st.count; // [R15]
		end

		// axi write
		if (wr_go) begin
			nx.bvalid = 1'b1;
			nx.bresp = `ATC_RESP_OKAY;
			wr_ok = s_axi_wstrb[0];
			unique case (s_axi_awaddr)
				`ATC_OFF_COUNT: begin
					if (wr_ok && st.asel) begin
						nx.h_cnt = '{value: wbyte, busy: 1'b1, edges: 2'h0}; // [R05] [R25]
					end else if (wr_ok) begin
						cnt_load = 1'b1;
						cnt_val = wbyte;
					end
				end
				`ATC_OFF_COMPARE: begin
					if (wr_ok && st.asel) begin
						nx.h_cmp = '{value: wbyte, busy: 1'b1, edges: 2'h0}; // [R05]
					end else if (wr_ok) begin
						nx.compare = wbyte;
					end
				end
				`ATC_OFF_CONTROL: begin
					if (wr_ok && st.asel) begin
						nx.h_ctl = '{value: wbyte, busy: 1'b1, edges: 2'h0}; // [R05]
					end else if (wr_ok) begin
						nx.control = wbyte;
					end
				end
				`ATC_OFF_STATUS: begin
					if (wr_ok) begin
						nx.asel = wbyte[`ATC_BIT_ASEL]; // [R18] [R26]
					end
				end
				`ATC_OFF_SFR: begin
					if (wr_ok) begin
						nx.psr = wbyte[`ATC_BIT_PSR]; // [R21]
					end
				end
				`ATC_OFF_FLAGS: begin
					if (wr_ok) begin
						nx.flag_ovf = st.flag_ovf && !wbyte[`ATC_BIT_OVF];
						nx.flag_cmp = st.flag_cmp && !wbyte[`ATC_BIT_CMPF];
					end
				end
				default: nx.bresp = `ATC_RESP_SLVERR;
			endcase
		end else if (st.bvalid && s_axi_bready) begin
			nx.bvalid = 1'b0;
		end

		// a count load blocks the next compare and wins over the increment
		if (cnt_load) begin
			nx.count = cnt_val;
			nx.cmp_block = 1'b1;
		end
		// set beats a same-cycle clear
		if (st.ovf_pipe[2]) begin
			nx.flag_ovf = 1'b1; // [R16]
		end
		if (st.cmp_pipe[2]) begin
			nx.flag_cmp = 1'b1; // [R16]
		end

		// axi read
		if (rd_go) begin
			nx.rvalid = 1'b1;
			nx.rresp = `ATC_RESP_OKAY;
			nx.rdata = '0;
			unique case (s_axi_araddr)
				`ATC_OFF_COUNT: nx.rdata[7:0] = st.count_copy; // [R15]
				`ATC_OFF_COMPARE: nx.rdata[7:0] = st.compare;
				`ATC_OFF_CONTROL: nx.rdata[7:0] = st.control;
				`ATC_OFF_STATUS: begin
					nx.rdata[`ATC_BIT_ASEL] = st.asel;
					// raw term makes busy visible at once; synced term holds it
					nx.rdata[`ATC_BIT_CNT_UB] = busy_seen[2]; // [R06]
					nx.rdata[`ATC_BIT_CMP_UB] = busy_seen[1]; // [R06]
					nx.rdata[`ATC_BIT_CTL_UB] = busy_seen[0]; // [R06]
				end
				`ATC_OFF_SFR: nx.rdata = '0;
				`ATC_OFF_FLAGS: begin
					nx.rdata[`ATC_BIT_OVF] = st.flag_ovf;
					nx.rdata[`ATC_BIT_CMPF] = st.flag_cmp;
				end
				default: nx.rresp = `ATC_RESP_SLVERR;
			endcase
		end else if (st.rvalid && s_axi_rready) begin
			nx.rvalid = 1'b0;
		end

		// wake sequencing
		unique case (st.wake)
			atc_pkg::atc_w_idle: begin
				if (wake_evt) begin
					nx.wake = atc_pkg::atc_w_pend;
				end
			end
			atc_pkg::atc_w_pend: begin
				if (tick) begin
					nx.wake = atc_pkg::atc_w_hold; // [R13]
					nx.hold_cnt = 3'h0;
				end
			end
			atc_pkg::atc_w_hold: begin
				nx.hold_cnt = st.hold_cnt + 1'b1;
				if (st.hold_cnt == `ATC_HOLD_LAST) begin
					nx.wake = atc_pkg::atc_w_rearm; // [R14]
				end
			end
			atc_pkg::atc_w_rearm: begin
				// events during this timer cycle cannot start a new wake
				if (psc_bus.src_en) begin
					nx.wake = atc_pkg::atc_w_idle; // [R10]
				end
			end
		endcase
	end

	// ce low freezes every stage, synchronisers included
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else if (ce) begin
			st <= nx;
		end
	end

	// bus handshakes
	// ready is combinational: taken only while the reply slot is free
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_arready = rd_go;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rresp = st.rresp;
	assign s_axi_rdata = st.rdata;

	// pins and sleep
	// pins stay claimed through sleep so the crystal keeps its load
	assign crystal_pins_claimed = st.asel; // [R19]
	assign osc_enable = st.asel && !deep_sleep; // [R11]
	// cpu_hold and handler_start decode the sequencer state directly; wake_req also needs tick
	assign crystal_out_pin = st.xout;
	assign compare_out = st.oc_out; // [R17]
	assign wake_req = st.wake == atc_pkg::atc_w_pend && tick; // [R13]
	assign cpu_hold = st.wake == atc_pkg::atc_w_hold; // [R14]
	assign handler_start = cpu_hold && st.hold_cnt == `ATC_HOLD_LAST; // [R14]
endmodule

// >>> verif/atc_monitor.sv
`timescale 1ns/1ps
`include "atc_consts.svh"

module atc_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// pins and sleep
	input wire logic crystal_out_pin,
	input wire logic crystal_pins_claimed,
	input wire logic osc_enable,
	input wire logic sleep_active,
	input wire logic [2:0] sleep_mode,
	input wire logic wake_req,
	input wire logic cpu_hold,
	input wire logic handler_start
);
	default clocking
		@(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic deep;
	assign deep = sleep_active && (sleep_mode == `ATC_SLEEP_PDOWN
		|| sleep_mode == `ATC_SLEEP_STANDBY);

	AST_B_TAKEN: assert property (ce && s_axi_awvalid && s_axi_wvalid && s_axi_awready
		&& s_axi_wready |=> s_axi_bvalid) else $error("write not answered");
	AST_B_STAND: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	AST_R_TAKEN: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	AST_R_STAND: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	AST_NO_REFILL: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	AST_OSC_DEEP: assert property (deep |-> !osc_enable)
		else $error("oscillator running in deep sleep");
	AST_OSC_RUN: assert property (crystal_pins_claimed && !deep |-> osc_enable)
		else $error("oscillator stopped");
	AST_CLAIM: assert property (osc_enable |-> crystal_pins_claimed)
		else $error("oscillator on while pins not claimed");
	AST_XOUT_QUIET: assert property (!osc_enable [*2] |-> !crystal_out_pin)
		else $error("crystal drive while oscillator off");
	AST_HOLD4: assert property ($rose(cpu_hold) |-> cpu_hold [*4] ##1 !cpu_hold)
		else $error("core hold not four cycles");
	AST_HANDLER: assert property ($rose(cpu_hold) |-> ##3 handler_start)
		else $error("handler start misplaced");
	AST_WAKE_HOLD: assert property (wake_req |-> ##[0:1] cpu_hold)
		else $error("wake without core hold");
endmodule

bind atc_timer_front atc_monitor u_atc_monitor (.*);

// >>> verif/atc_xtal_model.sv
`timescale 1ns/1ps

module atc_xtal_model #(
	parameter int HALF_NS = 103
) (
	// oscillator control
	input wire logic osc_enable,
	// crystal node
	output logic crystal_in_pin
);
	// scaled watch crystal, no external drive
	// period near 21 aclk cycles keeps aclk above four times the crystal rate
	initial begin
		crystal_in_pin = 1'b0;
		forever begin
			#(HALF_NS);
			// stopped oscillator sits low, no stale swing
			crystal_in_pin = osc_enable ? !crystal_in_pin : 1'b0;
		end
	end
endmodule

// >>> verif/tb.sv
`timescale 1ns/1ps
`include "atc_consts.svh"

module tb;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic crystal_in_pin, crystal_out_pin, crystal_pins_claimed, osc_enable, compare_out;
	logic sleep_active, wake_req, cpu_hold, handler_start;
	logic [2:0] sleep_mode;
	int error_cnt, compares, xedges;

	atc_timer_front u_atc_timer_front (.*);
	atc_xtal_model u_atc_xtal_model (.osc_enable(osc_enable), .crystal_in_pin(crystal_in_pin));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge crystal_in_pin) xedges++;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er = `ATC_RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk("bresp", er, s_axi_bresp);
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] er = `ATC_RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk("rresp", er, s_axi_rresp);
	endtask

	task automatic wait_idle();
		int k = 0;
		do begin
			rd(`ATC_OFF_STATUS);
			k++;
		end while (d[2:0] !== 3'h0 && k < 200);
		chk("busy", 3'h0, d[2:0]);
	endtask

	task automatic t_reset();
		for (int a = 0; a < 6; a++) begin
			rd(8'(a * 4));
			chk("reset", 32'h0000_0000, d);
		end
		rd(8'h18, `ATC_RESP_SLVERR);
		wr(8'h1C, 32'h0000_0001, `ATC_RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		wr(`ATC_OFF_COMPARE, 32'h0000_00FF);
		s_axi_wstrb <= 4'hF;
		rd(`ATC_OFF_COMPARE);
		chk("nostrb", 32'h0000_0000, d);
		chk("claimed", 1'b0, crystal_pins_claimed);
	endtask

	task automatic t_psc();
		int div[8] = '{5, 1, 8, 32, 64, 128, 256, 1024};
		for (int c = 0; c < 8; c++) begin
			wr(`ATC_OFF_COUNT, 32'h0000_0000);
			wr(`ATC_OFF_SFR, 32'h0000_0001);
			wr(`ATC_OFF_CONTROL, 32'(c));
			repeat (div[c] * 20) @(posedge aclk);
			wr(`ATC_OFF_CONTROL, 32'h0000_0000);
			rd(`ATC_OFF_COUNT);
			chk("ticks", 1'b1, c == 0 ? d == 0 : d >= 20 && d <= 25);
		end
		rd(`ATC_OFF_SFR);
		chk("psr", 32'h0000_0000, d);
	endtask

	task automatic t_match();
		wr(`ATC_OFF_COMPARE, 32'h0000_0040);
		wr(`ATC_OFF_CONTROL, 32'h0000_0011);
		repeat (100) @(posedge aclk);
		chk("oc", 1'b1, compare_out);
		wr(`ATC_OFF_CONTROL, 32'h0000_0010);
		rd(`ATC_OFF_FLAGS);
		chk("cmpf", 2'h2, d[1:0]);
		wr(`ATC_OFF_FLAGS, 32'h0000_0002);
		rd(`ATC_OFF_FLAGS);
		chk("flags", 32'h0000_0000, d);
	endtask

	task automatic t_async();
		int e0;
		logic oc0;
		wr(`ATC_OFF_STATUS, 32'h0000_0008);
		chk("claimed", 1'b1, crystal_pins_claimed);
		e0 = xedges;
		wr(`ATC_OFF_COUNT, 32'h0000_005A);
		wr(`ATC_OFF_COMPARE, 32'h0000_00A5);
		rd(`ATC_OFF_STATUS);
		chk("ub", 4'hE, d[3:0]);
		wait_idle();
		chk("edges", 1'b1, xedges - e0 >= 2 && xedges - e0 <= 3);
		// copy follows crystal edges, so let two more pass
		repeat (50) @(posedge aclk);
		rd(`ATC_OFF_COUNT);
		chk("count", 8'h5A, d);
		rd(`ATC_OFF_COMPARE);
		chk("compare", 8'hA5, d);
		wr(`ATC_OFF_CONTROL, 32'h0000_0011);
		wait_idle();
		oc0 = compare_out;
		wr(`ATC_OFF_COUNT, 32'h0000_00A5);
		wait_idle();
		repeat (60) @(posedge aclk);
		rd(`ATC_OFF_FLAGS);
		chk("nomatch", 1'b0, d[`ATC_BIT_CMPF]);
		chk("oc", oc0, compare_out);
		rd(`ATC_OFF_COUNT);
		chk("run", 1'b1, d >= 8'hA6 && d <= 8'hAB);
	endtask

	task automatic t_wake();
		int k = 0;
		wr(`ATC_OFF_COUNT, 32'h0000_00FD);
		wait_idle();
		wr(`ATC_OFF_FLAGS, 32'h0000_0003);
		sleep_active <= 1'b1;
		sleep_mode <= 3'h3;
		do begin
			@(posedge aclk);
			k++;
		end while (!wake_req && k < 500);
		chk("wake", 1'b1, wake_req);
		k = 0;
		do begin
			@(posedge aclk);
			k++;
		end while (!handler_start && k < 10);
		chk("handler", 1'b1, handler_start);
		sleep_active <= 1'b0;
		rd(`ATC_OFF_FLAGS);
		chk("ovf", 1'b1, d[`ATC_BIT_OVF]);
	endtask

	task automatic t_deep();
		int e0;
		for (int m = 0; m < 2; m++) begin
			sleep_active <= 1'b1;
			sleep_mode <= m ? `ATC_SLEEP_STANDBY : `ATC_SLEEP_PDOWN;
			repeat (2) @(posedge aclk);
			e0 = xedges;
			repeat (100) @(posedge aclk);
			chk("osc", 1'b0, osc_enable);
			chk("xedge", e0, xedges);
			sleep_active <= 1'b0; // nothing read back after deep sleep
			repeat (2) @(posedge aclk);
			chk("osc", 1'b1, osc_enable);
		end
	endtask

	task automatic t_ce();
		logic [31:0] d0;
		rd(`ATC_OFF_COUNT);
		d0 = d;
		@(posedge aclk);
		ce <= 1'b0;
		repeat (200) @(posedge aclk);
		ce <= 1'b1;
		rd(`ATC_OFF_COUNT);
		chk("frozen", 1'b1, d >= d0 && d <= d0 + 2);
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		ce = 1'b1;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		sleep_active = 1'b0;
		sleep_mode = 3'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_psc();
		t_match();
		t_async();
		t_wake();
		t_deep();
		t_ce();
		stop_test();
	end

	// run needs about 32000 cycles
	initial begin
		repeat (90000) @(posedge aclk);
		error_cnt++;
		stop_test();
	end
endmodule
